// [design/ftc_regs.vh]
// register offsets, field positions, reset values and timing for the fan/overtemp config block
//
// Notes on behaviour
// - alert select bit turns the second pwm pin into an active-low alert output
// - overtemp line is watched only when monitor enable is set and pin selected
// - full_speed_on_overtemp bit forces every fan to full duty while the watched overtemp line is asserted
// - fast bit shortens the speed measurement period from 1 s to 250 ms
// - each channel's continuous bit requests speed measurement on that channel all the time
// - lock bit makes config three and config four ignore all writes
// - duration bits 7:1 read zero until an assertion lasts beyond 45.52 ms
// - status bit 0 sets when the overtemp input asserts, clears when status is read
// - past 45.52 ms the status reads an 8-bit duration count in 22.76 ms steps
// - duration above the programmed limit sets bit 5 of interrupt status two
// - a zero limit raises that interrupt as soon as the input asserts
// - the limit is an 8-bit value in 22.76 ms steps
// - per fan 2-bit field picks one to four counted pulses, default two
// - volt pin alert select makes the 2.5 V pin an alert output, else an input
// - 2-bit field picks the two-wire threshold: 20, 40, 80 or 130 mV
// - mask bit 5 of interrupt mask two suppresses alert for the duration event
`ifndef FTC_REGS_VH
`define FTC_REGS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define FTC_IDX_CONFIG_ONE 8'h40
`define FTC_IDX_INT_STATUS_TWO 8'h42
`define FTC_IDX_INT_MASK_TWO 8'h75
`define FTC_IDX_CONFIG_THREE 8'h78
`define FTC_IDX_DURATION_STATUS 8'h79
`define FTC_IDX_DURATION_LIMIT 8'h7A
`define FTC_IDX_PULSES_PER_REV 8'h7B
`define FTC_IDX_CONFIG_FOUR 8'h7D

// ==========================================================
// field positions
`define FTC_C1_PIN_SEL 0
`define FTC_C1_LOCK 1
`define FTC_C3_ALERT_SEL 0
`define FTC_C3_MONITOR_EN 1
`define FTC_C3_FULL_SPEED_ON_OVERTEMP 2
`define FTC_C3_FAST 3
`define FTC_C3_CONT_LSB 4
`define FTC_C4_VOLT_ALERT 0
`define FTC_C4_THRESH_LSB 2
`define FTC_INT_OT_SEEN 0
`define FTC_INT_DURATION 5
`define FTC_C4_WRITE_MASK 8'h0D

// ==========================================================
// reset values
`define FTC_RST_ZERO 8'h00
`define FTC_RST_PULSES 8'h55

// ==========================================================
// timing
`define FTC_CLK_MHZ 125
`define FTC_STEP_US 22760
`define FTC_MEAS_SLOW_MS 1000
`define FTC_MEAS_FAST_MS 250
`define FTC_REPORT_MIN_STEPS 8'h02
`define FTC_DURATION_MAX 8'hFF

// ==========================================================
// bus answers
`define FTC_RESP_OKAY 2'h0
`define FTC_RESP_SLVERR 2'h2

`endif

// [design/ftc_config_regs.v]
// fan and overtemperature configuration registers with axi4-lite access
`include "ftc_regs.vh"

module ftc_config_regs #(
    parameter STEP_CYCLES = `FTC_STEP_US * `FTC_CLK_MHZ,
    parameter MEAS_SLOW_CYCLES = `FTC_MEAS_SLOW_MS * 1000 * `FTC_CLK_MHZ,
    parameter MEAS_FAST_CYCLES = `FTC_MEAS_FAST_MS * 1000 * `FTC_CLK_MHZ
) (
    // clock and reset
    input wire core_clk_i,
    input wire reset_n_i,
    // axi4-lite write address and data
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // overtemperature line pin, active low
    input wire overtemp_line_n_i,
    // pin functions and alerts
    output wire pwm2_pin_is_alert_o,
    output wire pwm2_alert_n_o,
    output wire volt_pin_is_alert_o,
    output wire volt_alert_n_o,
    output wire irq_o,
    // fan control
    output wire full_speed_on_overtemp_o,
    output wire [3:0] speed_meas_req_o,
    output wire [11:0] pulses_counted_o,
    output wire [1:0] two_wire_threshold_o
);

    // ==========================================================
    // registers
    reg [7:0] config_one;
    reg [7:0] config_three;
    reg [7:0] config_four;
    reg [7:0] overtemp_duration_status;
    reg [7:0] overtemp_duration_limit;
    reg [7:0] fan_pulses_per_rev;
    reg [7:0] int_status_two;
    reg [7:0] int_mask_two;

    // ==========================================================
    // address decode, shared by the read and write paths
    function [3:0] ftc_decode;
        input [11:0] addr;
        reg [7:0] idx;
        begin
            idx = addr[9:2];
            if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
                ftc_decode = 4'h0;
            end else if (idx == `FTC_IDX_CONFIG_ONE) begin
                ftc_decode = 4'h1;
            end else if (idx == `FTC_IDX_INT_STATUS_TWO) begin
                ftc_decode = 4'h2;
            end else if (idx == `FTC_IDX_INT_MASK_TWO) begin
                ftc_decode = 4'h3;
            end else if (idx == `FTC_IDX_CONFIG_THREE) begin
                ftc_decode = 4'h4;
            end else if (idx == `FTC_IDX_DURATION_STATUS) begin
                ftc_decode = 4'h5;
            end else if (idx == `FTC_IDX_DURATION_LIMIT) begin
                ftc_decode = 4'h6;
            end else if (idx == `FTC_IDX_PULSES_PER_REV) begin
                ftc_decode = 4'h7;
            end else if (idx == `FTC_IDX_CONFIG_FOUR) begin
                ftc_decode = 4'h8;
            end else begin
                ftc_decode = 4'h0;
            end
        end
    endfunction

    localparam [3:0] SEL_NONE = 4'h0;
    localparam [3:0] SEL_CFG1 = 4'h1;
    localparam [3:0] SEL_IST2 = 4'h2;
    localparam [3:0] SEL_IMSK2 = 4'h3;
    localparam [3:0] SEL_CFG3 = 4'h4;
    localparam [3:0] SEL_DSTAT = 4'h5;
    localparam [3:0] SEL_DLIM = 4'h6;
    localparam [3:0] SEL_PPR = 4'h7;
    localparam [3:0] SEL_CFG4 = 4'h8;

    // ==========================================================
    // write channel: address and data taken in either order
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [7:0] w_byte;
    reg w_lane0;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held;
    wire [3:0] wr_sel = ftc_decode(aw_addr);
    wire wr_en = wr_go && w_lane0; // only byte lane 0 carries data
    wire locked = config_one[`FTC_C1_LOCK];

    // hold each half until the other arrives, then answer
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FTC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_byte <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_sel == SEL_NONE) ? `FTC_RESP_SLVERR : `FTC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // read channel: one cycle from address to data
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [3:0] rd_sel = ftc_decode(s_axi_araddr);
    wire status_read = ar_take && (rd_sel == SEL_DSTAT);
    reg [7:0] next_rbyte;

    // read mux; reserved bits and unmapped words read zero
    always @* begin
        next_rbyte = 8'h00;
        case (rd_sel)
            SEL_CFG1: next_rbyte = config_one;
            SEL_IST2: next_rbyte = int_status_two;
            SEL_IMSK2: next_rbyte = int_mask_two;
            SEL_CFG3: next_rbyte = config_three;
            SEL_DSTAT: next_rbyte = overtemp_duration_status;
            SEL_DLIM: next_rbyte = overtemp_duration_limit;
            SEL_PPR: next_rbyte = fan_pulses_per_rev;
            SEL_CFG4: next_rbyte = config_four;
            default: next_rbyte = 8'h00;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `FTC_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, next_rbyte};
            s_axi_rresp <= (rd_sel == SEL_NONE) ? `FTC_RESP_SLVERR : `FTC_RESP_OKAY;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // overtemperature line synchroniser and edge detect
    reg ot_meta;
    reg ot_sync;
    reg ot_prev;

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            ot_meta <= 1'b0;
            ot_sync <= 1'b0;
            ot_prev <= 1'b0;
        end else begin
            ot_meta <= !overtemp_line_n_i;
            ot_sync <= ot_meta;
            ot_prev <= ot_sync;
        end
    end

    // watched only when enabled and the shared pin is the overtemp line
    wire monitoring = config_three[`FTC_C3_MONITOR_EN] && config_one[`FTC_C1_PIN_SEL];
    wire ot_active = monitoring && ot_sync;
    wire ot_rise = monitoring && ot_sync && !ot_prev;

    // ==========================================================
    // duration timer in 22.76 ms steps
    reg [31:0] step_cnt;
    reg [7:0] dur_steps;
    wire step_done = ot_active && !ot_rise && (step_cnt == STEP_CYCLES - 1);
    wire [7:0] next_steps = (dur_steps == `FTC_DURATION_MAX) ? dur_steps
                            : dur_steps + 8'h01;

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            step_cnt <= 32'h00000000;
            dur_steps <= 8'h00;
        end else if (ot_rise || !ot_active) begin
            step_cnt <= 32'h00000000; // a fresh assertion restarts timing
            dur_steps <= 8'h00;
        end else if (step_done) begin
            step_cnt <= 32'h00000000;
            dur_steps <= next_steps;
        end else begin
            step_cnt <= step_cnt + 32'h00000001;
        end
    end

    // past 45.52 ms the count replaces the seen flag
    wire dur_report = step_done && (next_steps > `FTC_REPORT_MIN_STEPS);

    // status: hardware set wins over the read-clear
    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            overtemp_duration_status <= `FTC_RST_ZERO;
        end else if (dur_report) begin
            overtemp_duration_status <= next_steps;
        end else if (ot_rise) begin
            overtemp_duration_status <= 8'h01;
        end else if (status_read) begin
            overtemp_duration_status <= `FTC_RST_ZERO;
        end
    end

    // limit crossing: zero fires on assertion, else when steps pass the limit
    wire limit_zero = (overtemp_duration_limit == 8'h00);
    wire limit_hit = (ot_rise && limit_zero)
                   || (step_done && !limit_zero && next_steps > overtemp_duration_limit
                       && dur_steps <= overtemp_duration_limit);

    // ==========================================================
    // register writes, interrupt status and lock
    wire cfg_write_ok = !locked;
    wire [7:0] ist_set;
    assign ist_set = {2'b00, limit_hit, 4'h0, ot_rise};

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            config_one <= `FTC_RST_ZERO;
            config_three <= `FTC_RST_ZERO;
            config_four <= `FTC_RST_ZERO;
            overtemp_duration_limit <= `FTC_RST_ZERO;
            fan_pulses_per_rev <= `FTC_RST_PULSES;
            int_mask_two <= `FTC_RST_ZERO;
            int_status_two <= `FTC_RST_ZERO;
        end else begin
            // write-one-to-clear, new events win in the same cycle
            if (wr_en && wr_sel == SEL_IST2) begin
                int_status_two <= (int_status_two & ~w_byte) | ist_set;
            end else begin
                int_status_two <= int_status_two | ist_set;
            end
            if (wr_en) begin
                if (wr_sel == SEL_CFG1) begin
                    // lock stays set until reset once written
                    config_one <= {6'h00, w_byte[`FTC_C1_LOCK] | locked, w_byte[0]};
                end else if (wr_sel == SEL_IMSK2) begin
                    int_mask_two <= w_byte;
                end else if (wr_sel == SEL_CFG3 && cfg_write_ok) begin
                    config_three <= w_byte;
                end else if (wr_sel == SEL_DLIM) begin
                    overtemp_duration_limit <= w_byte;
                end else if (wr_sel == SEL_PPR) begin
                    fan_pulses_per_rev <= w_byte;
                end else if (wr_sel == SEL_CFG4 && cfg_write_ok) begin
                    config_four <= w_byte & `FTC_C4_WRITE_MASK;
                end
            end
        end
    end

    // ==========================================================
    // interrupt and alert pins
    assign irq_o = |(int_status_two & ~int_mask_two);
    assign pwm2_pin_is_alert_o = config_three[`FTC_C3_ALERT_SEL];
    assign pwm2_alert_n_o = !(pwm2_pin_is_alert_o && irq_o);
    assign volt_pin_is_alert_o = config_four[`FTC_C4_VOLT_ALERT];
    assign volt_alert_n_o = !(volt_pin_is_alert_o && irq_o);
    assign two_wire_threshold_o = config_four[`FTC_C4_THRESH_LSB +: 2];

    // full_speed_on_overtemp holds only while the watched line stays asserted
    assign full_speed_on_overtemp_o = config_three[`FTC_C3_FULL_SPEED_ON_OVERTEMP] && ot_active;

    // ==========================================================
    // measurement period, quartered when fast
    reg [31:0] meas_cnt;
    reg meas_tick;
    wire [31:0] meas_last = config_three[`FTC_C3_FAST] ? MEAS_FAST_CYCLES - 1
                            : MEAS_SLOW_CYCLES - 1;

    always @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            meas_cnt <= 32'h00000000;
            meas_tick <= 1'b0;
        end else if (meas_cnt >= meas_last) begin
            meas_cnt <= 32'h00000000; // also catches a switch to fast mid period
            meas_tick <= 1'b1;
        end else begin
            meas_cnt <= meas_cnt + 32'h00000001;
            meas_tick <= 1'b0;
        end
    end

    // per channel request and pulse count
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
            assign speed_meas_req_o[ch] = meas_tick
                                        || config_three[`FTC_C3_CONT_LSB + ch];
            assign pulses_counted_o[3 * ch +: 3] = {1'b0, fan_pulses_per_rev[2 * ch +: 2]}
                                                 + 3'h1;
        end
    endgenerate

endmodule

// [tb/ftc_regs_assertions.sv]
// port-level assertion checker for the fan and overtemp config register block
module ftc_regs_checker (
    // clock and reset
    input wire core_clk_i,
    input wire reset_n_i,
    // bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // pins
    input wire overtemp_line_n_i,
    input wire pwm2_pin_is_alert_o,
    input wire pwm2_alert_n_o,
    input wire volt_pin_is_alert_o,
    input wire volt_alert_n_o,
    input wire irq_o,
    input wire full_speed_on_overtemp_o,
    input wire [11:0] pulses_counted_o,
    input wire [1:0] two_wire_threshold_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    // ==========================================================
    // write handshake steps
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence resp_waiting;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    // ==========================================================
    // bus assertions
    wr_resp_a: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    b_hold_a: assert property (resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    // ==========================================================
    // pin assertions
    pwm_alert_a: assert property (pwm2_alert_n_o == !(pwm2_pin_is_alert_o && irq_o))
        else $error("pwm2 alert level wrong");
    volt_alert_a: assert property (volt_alert_n_o == !(volt_pin_is_alert_o && irq_o))
        else $error("volt pin alert level wrong");
    // the line passes two sync flops, so look two edges back
    full_speed_on_overtemp_line_a: assert property (full_speed_on_overtemp_o |-> !$past(overtemp_line_n_i, 2))
        else $error("full speed without overtemp line");
    cfg_write_a: assert property ($changed({pwm2_pin_is_alert_o, volt_pin_is_alert_o,
        pulses_counted_o, two_wire_threshold_o}) |-> $rose(s_axi_bvalid))
        else $error("config output changed without a write");
endmodule

bind ftc_config_regs ftc_regs_checker i_ftc_regs_checker (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .overtemp_line_n_i(overtemp_line_n_i), .pwm2_pin_is_alert_o(pwm2_pin_is_alert_o),
    .pwm2_alert_n_o(pwm2_alert_n_o), .volt_pin_is_alert_o(volt_pin_is_alert_o),
    .volt_alert_n_o(volt_alert_n_o), .irq_o(irq_o),
    .full_speed_on_overtemp_o(full_speed_on_overtemp_o),
    .pulses_counted_o(pulses_counted_o), .two_wire_threshold_o(two_wire_threshold_o));

// [tb/ftc_overtemp_src.sv]
// behavioural source of the active-low overtemperature line
module ftc_overtemp_src (
    // clock and command
    input wire logic core_clk_i,
    input wire logic hold_low_i,
    // pin
    output logic overtemp_line_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the line has a pull-up, so a released line reads high, never a stale level
    initial overtemp_line_n_o = 1'h1;
    always @(posedge core_clk_i) begin
        overtemp_line_n_o <= ~hold_low_i;
    end
endmodule

// [tb/fan_overtemp_line_config_regs_tb_top.sv]
// self-checking bench for the fan and overtemp config register block
module fan_overtemp_line_config_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals and constants
    localparam int STEP = 20;
    localparam logic [1:0] OK = 2'h0, ERR = 2'h2;
    localparam logic [11:0] A_C1 = 12'h100, A_IS2 = 12'h108, A_M2 = 12'h1D4, A_C3 = 12'h1E0;
    localparam logic [11:0] A_ST = 12'h1E4, A_LIM = 12'h1E8, A_PPR = 12'h1EC, A_C4 = 12'h1F4;
    typedef struct packed {logic [11:0] a; logic [7:0] rst, w, exp;} ftc_row_t;
    ftc_row_t rows [5] = '{'{A_C3, 8'h00, 8'hF9, 8'hF9}, '{A_LIM, 8'h00, 8'h3C, 8'h3C},
        '{A_PPR, 8'h55, 8'hE4, 8'hE4}, '{A_C4, 8'h00, 8'hFF, 8'h0D}, '{A_M2, 8'h00, 8'h20, 8'h20}};
    logic clk = 1'h0, rst_n = 1'h0, hold_low = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h00000000, rd_val;
    logic [1:0] resp;
    wire awready, wready, bvalid, arready, rvalid, line_n, p2_is, p2_n, v_is, v_n, irq, full_speed_on_overtemp;
    wire [1:0] bresp, rresp, thr;
    wire [31:0] rdata;
    wire [3:0] meas;
    wire [11:0] pulses;
    int n_errors = 0, n_compared = 0;
    // short step count keeps the saturation test affordable
    ftc_config_regs #(.STEP_CYCLES(STEP), .MEAS_SLOW_CYCLES(40), .MEAS_FAST_CYCLES(10))
    i_ftc_config_regs (.core_clk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .overtemp_line_n_i(line_n), .pwm2_pin_is_alert_o(p2_is), .pwm2_alert_n_o(p2_n),
        .volt_pin_is_alert_o(v_is), .volt_alert_n_o(v_n), .irq_o(irq),
        .full_speed_on_overtemp_o(full_speed_on_overtemp), .speed_meas_req_o(meas), .pulses_counted_o(pulses),
        .two_wire_threshold_o(thr));
    ftc_overtemp_src i_ftc_overtemp_src (.core_clk_i(clk), .hold_low_i(hold_low),
        .overtemp_line_n_o(line_n));
    // 125 MHz clock
    initial forever #4 clk = ~clk;
    // ==========================================================
    // compare and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        chk(32'(got), 32'(exp), "bus response");
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // response ready is held back one cycle so the slave must keep its answer up
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'h1;
        end
        bready <= 1'h0;
        chk_resp(bresp, er);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'h1;
        end
        rready <= 1'h0;
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp, "read data");
        chk_resp(r, er);
    endtask
    task automatic count_ticks(input int exp);
        int n;
        n = 0;
        repeat (80) begin
            @(posedge clk);
            if (meas[0] === 1'h1) n++;
        end
        chk(32'(n), 32'(exp), "tick count");
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog sized well above the roughly 5800 cycles the tests need
    initial begin
        cyc(20000);
        n_errors++;
        conclude;
    end
    // ==========================================================
    // main sequence
    initial begin
        cyc(6);
        rst_n <= 1'h1;
        chk({pulses, irq, p2_n, v_n, meas, full_speed_on_overtemp}, {12'h492, 8'h60}, "reset pins");
        rdc(A_ST, 32'h00, OK);
        foreach (rows[i]) begin
            rdc(rows[i].a, 32'(rows[i].rst), OK);
            wr(rows[i].a, 32'(rows[i].w), OK);
            rdc(rows[i].a, 32'(rows[i].exp), OK);
        end
        chk({pulses, thr, v_is, p2_is, meas}, {12'h8D1, 8'hFF}, "pins");
        wr(12'h1F0, 32'h5A, ERR);
        wr(12'h1E1, 32'h5A, ERR);
        rdc(12'h1F0, 32'h00, ERR);
        for (int k = 0; k < 4; k++) begin
            wr(A_C4, 32'(k << 2), OK);
            chk(32'(thr), 32'(k), "threshold");
        end
        wr(A_C3, 32'h00, OK);
        cyc(40);
        count_ticks(2);
        wr(A_C3, 32'h08, OK);
        cyc(10);
        count_ticks(8);
        $display("test registers and ticks done");
        wr(A_C1, 32'h01, OK);
        wr(A_C3, 32'h05, OK);
        wr(A_LIM, 32'h00, OK);
        wr(A_M2, 32'h00, OK);
        hold_low <= 1'h1;
        cyc(8);
        chk({full_speed_on_overtemp, irq}, 2'h0, "monitor off");
        rdc(A_IS2, 32'h00, OK);
        hold_low <= 1'h0;
        cyc(6);
        wr(A_C3, 32'h07, OK);
        hold_low <= 1'h1;
        cyc(8);
        chk({full_speed_on_overtemp, irq, p2_n}, 3'h6, "overtemp on");
        rdc(A_IS2, 32'h21, OK);
        rdc(A_ST, 32'h01, OK);
        rdc(A_ST, 32'h00, OK);
        wr(A_M2, 32'h21, OK);
        chk(irq, 1'h0, "masked");
        hold_low <= 1'h0;
        cyc(6);
        chk(full_speed_on_overtemp, 1'h0, "overtemp off");
        wr(A_IS2, 32'h21, OK);
        wr(A_M2, 32'h01, OK);
        wr(A_LIM, 32'h03, OK);
        hold_low <= 1'h1;
        cyc(70);
        chk(irq, 1'h0, "below limit");
        cyc(20);
        chk(irq, 1'h1, "above limit");
        rdc(A_ST, 32'h04, OK);
        hold_low <= 1'h0;
        cyc(6);
        rd(A_ST, rd_val, resp);
        hold_low <= 1'h1;
        cyc(262 * STEP);
        rdc(A_ST, 32'hFF, OK);
        hold_low <= 1'h0;
        $display("test overtemp done");
        wr(A_C1, 32'h03, OK);
        wr(A_C3, 32'hFF, OK);
        rdc(A_C3, 32'h07, OK);
        wr(A_C4, 32'h01, OK);
        rdc(A_C4, 32'h0C, OK);
        chk(v_is, 1'h0, "locked pin");
        rst_n <= 1'h0;
        cyc(6);
        rst_n <= 1'h1;
        rdc(A_PPR, 32'h55, OK);
        wr(A_C3, 32'h01, OK);
        rdc(A_C3, 32'h01, OK);
        $display("test lock and reset done");
        conclude;
    end
endmodule
